/* File: bench/sapd_auto_powerdown_bench.sv */
/*
 * Self-checking bench for the auto powerdown controller.
 * Assumes the host model drives the register port and the checker is bound.
 */
`timescale 1ns/1ps
`include "sapd_consts.svh"
module sapd_auto_powerdown_bench;
    localparam int IDLE = 20;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, status_a, status_b, drive_input_status;
    logic reg_write, reg_read, rd_seen = 1'b0, seen;
    logic host_reset_in = 1'b0, fdc_int_pending = 1'b1, head_unload_expired = 1'b1;
    logic [7:0] main_status = 8'h80;
    logic motor_on_core, drive_select_core, write_data_core, write_gate_core;
    logic step_direction_core, step_pulse_core, head_select_core, fdc_irq_core, fdc_drq_core;
    logic [1:0] density_select_core, density_select_out;
    logic motor_on_out, motor_on_oe, drive_select_out, drive_select_oe, write_data_out;
    logic write_data_oe, write_gate_out, write_gate_oe, step_direction_out, step_pulse_out;
    logic head_select_out, fdc_irq_out, fdc_drq_out, fdc_powered_down, fdc_soft_reset;
    logic [1:0] tx_holding_empty = 2'b00, tx_shift_empty = 2'b11, tx_buffer_write = 2'b00;
    logic [1:0] rx_fifo_empty = 2'b00, rx_waiting_start = 2'b11, serial_receive_input = 2'b11;
    logic [1:0] ring_indicator_input = 2'b00, tx_powered_down, rx_powered_down, ring_change;
    sapd_pkg::sapd_par_cfg_t par_cfg_mode = sapd_pkg::sapd_cfg_spp;
    sapd_pkg::sapd_ecr_mode_t ecr_mode = sapd_pkg::sapd_ecr_spp;
    logic epp_powered_down, ecp_powered_down;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int checks = 0;
    int n;

    sapd_auto_powerdown #(.IDLE_CYCLES(IDLE)) dut_u (.*);
    sapd_host_model host_u (.clk_sys, .reg_addr, .reg_wdata, .reg_write, .reg_read);

    // Clock of 100 ns period.
    always #50 clk_sys = ~clk_sys;
    // Drive-side core values change at random every cycle.
    always @(posedge clk_sys) {motor_on_core, drive_select_core, write_data_core,
        write_gate_core, step_direction_core, step_pulse_core, head_select_core, fdc_irq_core,
        fdc_drq_core, density_select_core} <= 11'($urandom);

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: level %b want %b", $time, got, exp);
        end
    endtask
    // Notes the expected answer, then issues the read.
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask
    task automatic wait_down(output int k);
        k = 0;
        while (fdc_powered_down !== 1'b1 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Each read answer is compared with the oldest note.
    always @(posedge clk_sys) rd_seen <= reg_read;
    always @(negedge clk_sys) if (rd_seen) chk_rd(reg_rdata, exp_q.pop_front());

    // Cuts a hang short.
    initial begin
        #2000000;
        n_fail++;
        results();
    end

    // Main sequence.
    initial begin
        void'($urandom(88));
        status_a = 8'($urandom);
        status_b = 8'($urandom);
        drive_input_status = 8'($urandom);
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(3'h2, 8'h04);
        rd(`SAPD_OFS_AUTO_CFG, 8'h00);
        rd(`SAPD_OFS_PWR_STATUS, 8'h00);
        $display("test reset values done");
        host_u.wr(`SAPD_OFS_AUTO_CFG, 8'h01);
        repeat (IDLE + 10) @(posedge clk_sys);
        chk_bit(fdc_powered_down, 1'b0);
        fdc_int_pending <= 1'b0;
        wait_down(n);
        chk_bit(n >= IDLE && n <= IDLE + 3, 1'b1);
        chk_bit(motor_on_oe | write_gate_oe, 1'b0);
        rd(3'h0, status_a);
        rd(3'h1, status_b);
        rd(3'h7, drive_input_status);
        host_u.wr(3'h2, 8'h07);
        host_u.wr(3'h4, 8'h02);
        host_u.wr(3'h7, 8'h01);
        rd(3'h2, 8'h07);
        rd(`SAPD_OFS_PWR_STATUS, 8'h01);
        @(negedge clk_sys);
        chk_bit(fdc_powered_down, 1'b1);
        @(posedge clk_sys);
        $display("test quiet access done");
        for (int k = 0; k < 7; k++) begin
            wait_down(n);
            chk_bit(fdc_powered_down === 1'b1 && (k == 0 || n >= IDLE), 1'b1);
            case (k)
                0: rd(3'h4, main_status);
                1: rd(3'h5, 8'h00);
                2: host_u.wr(3'h5, 8'h00);
                3: host_u.wr(3'h2, 8'h14);
                4: host_u.wr(3'h2, 8'h00);
                5: host_u.wr(3'h4, 8'h80);
                default: begin
                    host_reset_in <= 1'b1;
                    @(posedge clk_sys);
                    host_reset_in <= 1'b0;
                end
            endcase
            @(negedge clk_sys);
            chk_bit(fdc_powered_down, 1'b0);
            @(posedge clk_sys);
            host_u.wr(3'h2, 8'h04);
        end
        chk_bit(fdc_soft_reset, 1'b1);
        $display("test floppy wake done");
        host_u.wr(`SAPD_OFS_AUTO_CFG, 8'h39);
        tx_holding_empty <= 2'b11;
        rx_fifo_empty <= 2'b11;
        repeat (3) @(posedge clk_sys);
        chk_bit(tx_powered_down === 2'b11 && rx_powered_down === 2'b11, 1'b1);
        for (int u = 0; u < 2; u++) begin
            tx_buffer_write[u] <= 1'b1;
            serial_receive_input[u] <= 1'b0;
            @(posedge clk_sys);
            tx_buffer_write[u] <= 1'b0;
            @(negedge clk_sys);
            chk_bit(tx_powered_down[u] | rx_powered_down[u], 1'b0);
            @(posedge clk_sys);
            ring_indicator_input[u] <= ~ring_indicator_input[u];
            seen = 1'b0;
            repeat (3) begin
                @(negedge clk_sys);
                seen |= ring_change[u];
            end
            chk_bit(seen, 1'b1);
            @(posedge clk_sys);
        end
        host_u.wr(`SAPD_OFS_AUTO_CFG, 8'h09);
        repeat (3) @(posedge clk_sys);
        chk_bit(|{tx_powered_down, rx_powered_down}, 1'b0);
        $display("test serial done");
        for (int c = 0; c < 40; c++) begin
            if (c == 32)
                host_u.wr(`SAPD_OFS_AUTO_CFG, 8'h01);
            par_cfg_mode <= sapd_pkg::sapd_par_cfg_t'(c[4:3]);
            ecr_mode <= sapd_pkg::sapd_ecr_mode_t'(c[2:0]);
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk_bit(epp_powered_down, c < 32 && (!c[3] || (c[4] && c[2:0] != 3'h4)));
            chk_bit(ecp_powered_down, c < 32 && (!c[4] || c[2:0] inside {0, 1, 4}));
            @(posedge clk_sys);
        end
        $display("test parallel done");
        repeat (3) @(posedge clk_sys);
        results();
    end
endmodule

/* File: bench/sapd_auto_powerdown_sva.sv */
/*
 * Checker for the auto powerdown controller.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`include "sapd_consts.svh"
module sapd_auto_powerdown_sva #(
    parameter int IDLE_CYCLES = 20,
    parameter int NUM_UARTS = 2
) (
    // Clock, reset and host side.
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic host_reset_in,
    // Floppy side.
    input wire logic [7:0] main_status,
    input wire logic fdc_int_pending,
    input wire logic head_unload_expired,
    input wire logic step_pulse_core,
    input wire logic step_pulse_out,
    input wire logic motor_on_oe,
    input wire logic drive_select_oe,
    input wire logic write_data_oe,
    input wire logic write_gate_oe,
    input wire logic fdc_irq_out,
    input wire logic fdc_drq_out,
    input wire logic fdc_powered_down,
    // Serial side.
    input wire logic [NUM_UARTS-1:0] tx_holding_empty,
    input wire logic [NUM_UARTS-1:0] tx_shift_empty,
    input wire logic [NUM_UARTS-1:0] tx_buffer_write,
    input wire logic [NUM_UARTS-1:0] serial_receive_input,
    input wire logic [NUM_UARTS-1:0] ring_indicator_input,
    input wire logic [NUM_UARTS-1:0] tx_powered_down,
    input wire logic [NUM_UARTS-1:0] rx_powered_down,
    input wire logic [NUM_UARTS-1:0] ring_change
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    float_pins_a: assert property (fdc_powered_down |->
        !(motor_on_oe | drive_select_oe | write_data_oe | write_gate_oe))
        else $error("drive outputs driven while powered down");
    live_pins_a: assert property ($past(reset_n) |->
        step_pulse_out == $past(step_pulse_core)) else $error("step output not driven");
    host_quiet_a: assert property (fdc_powered_down && $past(fdc_powered_down) |->
        !fdc_irq_out && !fdc_drq_out) else $error("request output active while down");
    read_wake_a: assert property ((reg_read && reg_addr inside {3'h4, 3'h5}) ||
        (reg_write && reg_addr == 3'h5) |=> !fdc_powered_down) else $error("no wake");
    quiet_read_a: assert property (fdc_powered_down && reg_read && !host_reset_in &&
        reg_addr inside {3'h0, 3'h1, 3'h2, 3'h7} |=> fdc_powered_down)
        else $error("status read woke the floppy");
    motor_wake_a: assert property (reg_write && ((reg_addr == 3'h2 &&
        (reg_wdata[4] || !reg_wdata[2])) || (reg_addr == 3'h4 && reg_wdata[7]))
        |=> !fdc_powered_down) else $error("motor or reset write did not wake");
    cfg_cancel_a: assert property (reg_write && reg_addr == `SAPD_OFS_AUTO_CFG &&
        !reg_wdata[0] |=> !fdc_powered_down) else $error("disable did not wake");
    reset_wake_a: assert property (host_reset_in |=> !fdc_powered_down)
        else $error("host reset did not wake");
    fdc_entry_a: assert property ($rose(fdc_powered_down) |-> $past(main_status == 8'h80 &&
        !fdc_int_pending && head_unload_expired)) else $error("floppy slept while busy");
    tx_entry_a: assert property ($rose(tx_powered_down[0]) |->
        $past(tx_holding_empty[0] && tx_shift_empty[0])) else $error("transmitter slept busy");
    tx_wake_a: assert property (tx_buffer_write[0] |=> !tx_powered_down[0])
        else $error("buffer write did not wake");
    rx_wake_a: assert property (serial_receive_input[0] != $past(serial_receive_input[0])
        |=> !rx_powered_down[0]) else $error("receive edge did not wake");
    ring_a: assert property ($changed(ring_indicator_input[0]) |-> ##[0:2] ring_change[0])
        else $error("ring change lost");
endmodule

bind sapd_auto_powerdown sapd_auto_powerdown_sva #(.IDLE_CYCLES(IDLE_CYCLES),
    .NUM_UARTS(NUM_UARTS)) chk_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .host_reset_in, .main_status, .fdc_int_pending, .head_unload_expired,
    .step_pulse_core, .step_pulse_out, .motor_on_oe, .drive_select_oe, .write_data_oe,
    .write_gate_oe, .fdc_irq_out, .fdc_drq_out, .fdc_powered_down, .tx_holding_empty,
    .tx_shift_empty, .tx_buffer_write, .serial_receive_input, .ring_indicator_input,
    .tx_powered_down, .rx_powered_down, .ring_change);

/* File: bench/sapd_host_model.sv */
/*
 * Host bus model that issues register reads and writes.
 * Assumes its tasks are entered just after a rising clock edge.
 */
`timescale 1ns/1ps
module sapd_host_model (
    // Clock.
    input wire logic clk_sys,
    // Register port.
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    // The bus is idle at time zero.
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // One write cycle; the data flips afterwards so stale data is never trusted.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // One read cycle; the answer is judged by the bench.
    task automatic rd(input logic [2:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
    endtask
endmodule

/* File: rtl/sapd_auto_powerdown.sv */
/*
 * Auto powerdown controller for the floppy, two serial ports and the
 * parallel port of a multi-function I/O controller.
 * Assumes a 10 MHz system clock, host bus signals already synchronous,
 * and unit cores that report their idle conditions as plain levels.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "sapd_consts.svh"

module sapd_auto_powerdown #(
    parameter int IDLE_CYCLES = `SAPD_IDLE_CYCLES,
    parameter int NUM_UARTS = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Host register port.
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Host bus reset.
    input wire logic host_reset_in,
    // Floppy core status.
    input wire logic [7:0] main_status,
    input wire logic [7:0] status_a,
    input wire logic [7:0] status_b,
    input wire logic [7:0] drive_input_status,
    input wire logic fdc_int_pending,
    input wire logic head_unload_expired,
    input wire logic fdc_irq_core,
    input wire logic fdc_drq_core,
    // Floppy drive outputs from the core.
    input wire logic motor_on_core,
    input wire logic drive_select_core,
    input wire logic write_data_core,
    input wire logic write_gate_core,
    input wire logic step_direction_core,
    input wire logic step_pulse_core,
    input wire logic head_select_core,
    input wire logic [1:0] density_select_core,
    // Floppy drive pins.
    output logic motor_on_out,
    output logic motor_on_oe,
    output logic drive_select_out,
    output logic drive_select_oe,
    output logic write_data_out,
    output logic write_data_oe,
    output logic write_gate_out,
    output logic write_gate_oe,
    output logic step_direction_out,
    output logic step_pulse_out,
    output logic head_select_out,
    output logic [1:0] density_select_out,
    // Floppy host outputs and wake indication.
    output logic fdc_irq_out,
    output logic fdc_drq_out,
    output logic fdc_powered_down,
    output logic fdc_soft_reset,
    // Serial port status and pins.
    input wire logic [NUM_UARTS-1:0] tx_holding_empty,
    input wire logic [NUM_UARTS-1:0] tx_shift_empty,
    input wire logic [NUM_UARTS-1:0] tx_buffer_write,
    input wire logic [NUM_UARTS-1:0] rx_fifo_empty,
    input wire logic [NUM_UARTS-1:0] rx_waiting_start,
    input wire logic [NUM_UARTS-1:0] serial_receive_input,
    input wire logic [NUM_UARTS-1:0] ring_indicator_input,
    output logic [NUM_UARTS-1:0] tx_powered_down,
    output logic [NUM_UARTS-1:0] rx_powered_down,
    output logic [NUM_UARTS-1:0] ring_change,
    // Parallel port configuration.
    input wire sapd_pkg::sapd_par_cfg_t par_cfg_mode,
    input wire sapd_pkg::sapd_ecr_mode_t ecr_mode,
    output logic epp_powered_down,
    output logic ecp_powered_down
);

    logic [7:0] auto_power_config;
    logic [7:0] drive_output_control;
    logic [7:0] rate_select;
    logic [7:0] rate_config_control;
    sapd_pkg::sapd_fdc_state_t fdc_state;
    logic [$clog2(IDLE_CYCLES+1)-1:0] idle_count;
    logic fdc_wake;
    logic fdc_idle;
    logic fdc_down;
    logic [NUM_UARTS-1:0] rx_last;
    logic [NUM_UARTS-1:0] ri_last;

    // Host accesses that end floppy powerdown: main status read, data access.
    // Output-control and rate writes wake only on motor enable or reset.
    // Reads of status_a, status_b, output control and input status never wake.
    always_comb begin
        fdc_wake = host_reset_in;
        if (reg_read && (reg_addr == `SAPD_OFS_RATE_MAIN ||
                reg_addr == `SAPD_OFS_CMD_DATA)) begin
            fdc_wake = 1'b1;
        end
        if (reg_write && reg_addr == `SAPD_OFS_CMD_DATA) begin
            fdc_wake = 1'b1;
        end
        if (reg_write && reg_addr == `SAPD_OFS_DRIVE_OUT &&
                (reg_wdata[`SAPD_DOC_MOTOR_BIT] ||
                 !reg_wdata[`SAPD_DOC_RESET_N_BIT])) begin
            fdc_wake = 1'b1;
        end
        if (reg_write && reg_addr == `SAPD_OFS_RATE_MAIN &&
                reg_wdata[`SAPD_RSEL_RESET_BIT]) begin
            fdc_wake = 1'b1;
        end
    end

    // Floppy idle conditions for entering powerdown.
    assign fdc_idle = !drive_output_control[`SAPD_DOC_MOTOR_BIT] &&
        main_status == `SAPD_MSR_IDLE && !fdc_int_pending && head_unload_expired;

    // Register writes; non-waking writes are retained during powerdown.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            auto_power_config <= `SAPD_CFG_RESET;
            drive_output_control <= `SAPD_DOC_RESET;
            rate_select <= 8'h00;
            rate_config_control <= 8'h00;
        end else if (reg_write) begin
            unique case (reg_addr)
                `SAPD_OFS_AUTO_CFG: auto_power_config <= reg_wdata;
                `SAPD_OFS_DRIVE_OUT: drive_output_control <= reg_wdata;
                `SAPD_OFS_RATE_MAIN: rate_select <= reg_wdata;
                `SAPD_OFS_DRIVE_IN: rate_config_control <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; status reads give live values.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                `SAPD_OFS_STATUS_A: reg_rdata <= status_a;
                `SAPD_OFS_STATUS_B: reg_rdata <= status_b;
                `SAPD_OFS_DRIVE_OUT: reg_rdata <= drive_output_control;
                `SAPD_OFS_AUTO_CFG: reg_rdata <= auto_power_config;
                `SAPD_OFS_RATE_MAIN: reg_rdata <= main_status;
                `SAPD_OFS_CMD_DATA: reg_rdata <= 8'h00;
                `SAPD_OFS_PWR_STATUS: reg_rdata <= {2'h0, ecp_powered_down,
                    epp_powered_down, rx_powered_down[0], tx_powered_down[0],
                    1'b0, fdc_down};
                `SAPD_OFS_DRIVE_IN: reg_rdata <= drive_input_status;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Idle timer: runs while enabled and idle, cancelled by disable or wake.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idle_count <= '0;
        end else if (!auto_power_config[`SAPD_CFG_FDC_BIT] || fdc_wake || !fdc_idle) begin
            idle_count <= '0;
        end else if (idle_count != ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES)) begin
            idle_count <= idle_count + 1'b1;
        end
    end

    // Floppy power state; a wake wins over entry in the same cycle.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fdc_state <= sapd_pkg::sapd_fdc_awake;
        end else begin
            unique case (fdc_state)
                sapd_pkg::sapd_fdc_awake: begin
                    if (!fdc_wake && fdc_idle && auto_power_config[`SAPD_CFG_FDC_BIT] &&
                            idle_count == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES)) begin
                        fdc_state <= sapd_pkg::sapd_fdc_down;
                    end
                end
                sapd_pkg::sapd_fdc_down: begin
                    if (fdc_wake || !auto_power_config[`SAPD_CFG_FDC_BIT]) begin
                        fdc_state <= sapd_pkg::sapd_fdc_awake;
                    end
                end
            endcase
        end
    end

    assign fdc_down = fdc_state == sapd_pkg::sapd_fdc_down;

    // Software reset request to the core from output control or rate select.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fdc_soft_reset <= 1'b0;
        end else begin
            fdc_soft_reset <= !drive_output_control[`SAPD_DOC_RESET_N_BIT] ||
                rate_select[`SAPD_RSEL_RESET_BIT];
        end
    end

    // Drive pins: motor, select and write lines float; positioning lines stay driven.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            motor_on_out <= 1'b1;
            drive_select_out <= 1'b1;
            write_data_out <= 1'b1;
            write_gate_out <= 1'b1;
            step_direction_out <= 1'b1;
            step_pulse_out <= 1'b1;
            head_select_out <= 1'b1;
            density_select_out <= 2'h0;
        end else begin
            motor_on_out <= motor_on_core;
            drive_select_out <= drive_select_core;
            write_data_out <= write_data_core;
            write_gate_out <= write_gate_core;
            step_direction_out <= step_direction_core;
            step_pulse_out <= step_pulse_core;
            head_select_out <= head_select_core;
            density_select_out <= density_select_core;
        end
    end

    assign motor_on_oe = !fdc_down;
    assign drive_select_oe = !fdc_down;
    assign write_data_oe = !fdc_down;
    assign write_gate_oe = !fdc_down;

    // Host interrupt and request outputs are held low from the second cycle of powerdown.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fdc_irq_out <= 1'b0;
            fdc_drq_out <= 1'b0;
        end else begin
            fdc_irq_out <= fdc_down ? 1'b0 : fdc_irq_core;
            fdc_drq_out <= fdc_down ? 1'b0 : fdc_drq_core;
        end
    end

    assign fdc_powered_down = fdc_down;

    // Per serial port transmit and receive powerdown.
    for (genvar u = 0; u < NUM_UARTS; u++) begin : g_uart
        logic enabled;
        assign enabled = auto_power_config[`SAPD_CFG_SER1_BIT + u];

        // Transmitter sleeps when both stages are empty, wakes on a buffer write.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                tx_powered_down[u] <= 1'b0;
            end else if (!enabled || tx_buffer_write[u]) begin
                tx_powered_down[u] <= 1'b0;
            end else if (tx_holding_empty[u] && tx_shift_empty[u]) begin
                tx_powered_down[u] <= 1'b1;
            end
        end

        // Receiver sleeps when empty and idle, wakes on any data edge.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                rx_last[u] <= 1'b1;
                rx_powered_down[u] <= 1'b0;
            end else begin
                rx_last[u] <= serial_receive_input[u];
                if (!enabled || rx_last[u] != serial_receive_input[u]) begin
                    rx_powered_down[u] <= 1'b0;
                end else if (rx_fifo_empty[u] && rx_waiting_start[u]) begin
                    rx_powered_down[u] <= 1'b1;
                end
            end
        end

        // Ring change detection is kept regardless of power state.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                ri_last[u] <= 1'b0;
                ring_change[u] <= 1'b0;
            end else begin
                ri_last[u] <= ring_indicator_input[u];
                ring_change[u] <= ri_last[u] != ring_indicator_input[u];
            end
        end
    end

    // Parallel port enhanced logic powerdown from current modes.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            epp_powered_down <= 1'b0;
            ecp_powered_down <= 1'b0;
        end else if (!auto_power_config[`SAPD_CFG_PAR_BIT]) begin
            epp_powered_down <= 1'b0;
            ecp_powered_down <= 1'b0;
        end else begin
            epp_powered_down <= (par_cfg_mode != sapd_pkg::sapd_cfg_epp &&
                par_cfg_mode != sapd_pkg::sapd_cfg_ecp_epp) ||
                (par_cfg_mode == sapd_pkg::sapd_cfg_ecp_epp &&
                 ecr_mode != sapd_pkg::sapd_ecr_epp);
            ecp_powered_down <= (par_cfg_mode != sapd_pkg::sapd_cfg_ecp &&
                par_cfg_mode != sapd_pkg::sapd_cfg_ecp_epp) ||
                ecr_mode == sapd_pkg::sapd_ecr_spp ||
                ecr_mode == sapd_pkg::sapd_ecr_byte ||
                ecr_mode == sapd_pkg::sapd_ecr_epp;
        end
    end

endmodule

/* File: rtl/sapd_consts.svh */
/*
 * Constants for the auto powerdown controller: host register offsets,
 * configuration bit positions, field positions and timing counts.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef SAPD_CONSTS_SVH
`define SAPD_CONSTS_SVH

// Floppy host register offsets.
`define SAPD_OFS_STATUS_A 3'h0
`define SAPD_OFS_STATUS_B 3'h1
`define SAPD_OFS_DRIVE_OUT 3'h2
`define SAPD_OFS_RATE_MAIN 3'h4
`define SAPD_OFS_CMD_DATA 3'h5
`define SAPD_OFS_DRIVE_IN 3'h7
// Own control offsets for the auto power configuration and status.
`define SAPD_OFS_AUTO_CFG 3'h3
`define SAPD_OFS_PWR_STATUS 3'h6

// Auto power configuration bit positions.
`define SAPD_CFG_FDC_BIT 0
`define SAPD_CFG_PAR_BIT 3
`define SAPD_CFG_SER1_BIT 4
`define SAPD_CFG_SER2_BIT 5

// Drive output control fields.
`define SAPD_DOC_RESET_N_BIT 2
`define SAPD_DOC_MOTOR_BIT 4
// Rate select software reset bit.
`define SAPD_RSEL_RESET_BIT 7

// Idle main status value.
`define SAPD_MSR_IDLE 8'h80
// Reset values.
`define SAPD_DOC_RESET 8'h04
`define SAPD_CFG_RESET 8'h00

// Idle timer: 10 ms at 100 ns per cycle.
`define SAPD_IDLE_TIME_NS 10000000
`define SAPD_CLK_PERIOD_NS 100
`define SAPD_IDLE_CYCLES (`SAPD_IDLE_TIME_NS / `SAPD_CLK_PERIOD_NS)

`endif

/* File: rtl/sapd_pkg.sv */
/*
 * Types for the auto powerdown controller.
 * Assumes nothing of its surroundings.
 */
package sapd_pkg;

    // Parallel port configured mode.
    typedef enum logic [1:0] {
        sapd_cfg_spp,
        sapd_cfg_epp,
        sapd_cfg_ecp,
        sapd_cfg_ecp_epp
    } sapd_par_cfg_t;

    // Extended control register mode field values.
    typedef enum logic [2:0] {
        sapd_ecr_spp,
        sapd_ecr_byte,
        sapd_ecr_fifo,
        sapd_ecr_ecp,
        sapd_ecr_epp,
        sapd_ecr_rsvd,
        sapd_ecr_test,
        sapd_ecr_cfg
    } sapd_ecr_mode_t;

    // Floppy power state.
    typedef enum logic [1:0] {
        sapd_fdc_awake,
        sapd_fdc_down
    } sapd_fdc_state_t;

endpackage
